// File: fifo_pkg.sv
// Shared constants for the single-clock 9-bit buffer with APB control.
// Assumes one clock domain; offsets are byte addresses of 32-bit words.
package fifo_pkg;

    // Data path shape
    localparam int DATA_W = 9;
    localparam int DEPTH  = 64;

    // APB register byte offsets
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_STATUS   = 8'h04;
    localparam logic [7:0] A_AE_OFF   = 8'h08;
    localparam logic [7:0] A_AF_OFF   = 8'h0C;
    localparam logic [7:0] A_INT_STAT = 8'h10;
    localparam logic [7:0] A_INT_MASK = 8'h14;

    // Control register fields
    localparam int CTRL_FLUSH_BIT = 0;

    // Status register fields
    localparam int ST_FULL_N_BIT  = 0;
    localparam int ST_EMPTY_N_BIT = 1;
    localparam int ST_AE_N_BIT    = 2;
    localparam int ST_AF_N_BIT    = 3;
    localparam int ST_MODE_BIT    = 4;
    localparam int ST_COUNT_LSB   = 16;

    // Interrupt event bits, same layout in status and mask
    localparam int EV_FULL  = 0;
    localparam int EV_EMPTY = 1;
    localparam int EV_AE    = 2;
    localparam int EV_AF    = 3;
    localparam int EV_OVER  = 4;
    localparam int EV_UNDER = 5;
    localparam int EV_W     = 6;

    // Offset reset values
    localparam int AE_OFF_RST = 7;
    localparam int AF_OFF_RST = 7;

    // Bus answer constants
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // What the dual-purpose write pin was strapped to at reset
    typedef enum logic {MODE_LOAD, MODE_ENABLE} pin_mode_t;

    // Which offset the next load strobe writes
    typedef enum logic {LOAD_AE, LOAD_AF} load_sel_t;

endpackage

// File: fifo_storage.sv
// Word array with write and read pointers and a registered read port.
// Assumes the caller only requests writes when not full and reads when not empty.
`timescale 1ns/1ps
module fifo_storage #(
    parameter int DATA_W = fifo_pkg::DATA_W,
    parameter int DEPTH  = fifo_pkg::DEPTH
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              flush,
    input  wire logic              wr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata_q
);
    localparam int ADDR_W = $clog2(DEPTH);

    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] wptr_q;
    logic [ADDR_W-1:0] rptr_q;

    // Array holds no reset: contents are meaningless until written
    always_ff @(posedge pclk) begin
        if (wr) begin
            mem[wptr_q] <= wdata;
        end
    end

    // Pointers wrap naturally since depth is a power of two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else if (flush) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            if (wr) wptr_q <= wptr_q + ADDR_W'(1);
            if (rd) rptr_q <= rptr_q + ADDR_W'(1);
        end
    end

    // Output word low out of reset, updated only on an accepted read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else if (rd) begin
            rdata_q <= mem[rptr_q];
        end
    end
endmodule

// File: fifo_occupancy.sv
// Word count and the four active-low status flags, all registered.
// Assumes wr and rd are already qualified against full and empty.
`timescale 1ns/1ps
module fifo_occupancy #(
    parameter int DEPTH = fifo_pkg::DEPTH
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       flush,
    input  wire logic                       wr,
    input  wire logic                       rd,
    input  wire logic [$clog2(DEPTH)-1:0]   ae_off,
    input  wire logic [$clog2(DEPTH)-1:0]   af_off,
    output logic      [$clog2(DEPTH):0]     count_q,
    output logic                            full_n_q,
    output logic                            empty_n_q,
    output logic                            ae_n_q,
    output logic                            af_n_q
);
    localparam int CNT_W = $clog2(DEPTH) + 1;
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] af_level;

    // Next occupancy; a simultaneous write and read cancel
    assign count_d  = flush ? '0 : count_q + CNT_W'(wr) - CNT_W'(rd);
    assign af_level = DEPTH_C - {1'b0, af_off};

    // Flags follow the same edge that moves the count: one clock, so skew is always met
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q   <= '0;
            full_n_q  <= 1'b1;
            empty_n_q <= 1'b0;
            ae_n_q    <= 1'b0;
            af_n_q    <= 1'b1;
        end else begin
            count_q   <= count_d;
            full_n_q  <= count_d != DEPTH_C;
            empty_n_q <= count_d != '0;
            ae_n_q    <= count_d >= {1'b0, ae_off};
            af_n_q    <= count_d < af_level;
        end
    end
endmodule

// File: fifo_top.sv
// Behaviour
// - full flag releases on the clock after a read
// - empty flag releases on the clock after a write
// - clocks may keep running during reset
// - pin high at reset makes it second write enable
// - pin low at reset makes it offset load strobe
// - outputs low when enabled, released when not, after reset
// - first word readable the cycle after empty releases
// - first word latency is one clock at the empty boundary
// - almost-empty updates on the edge that moved the count
// - almost-empty low when count below programmed offset
// - almost-full low when count reaches depth minus offset
// - almost-full updates on the edge that moved the count
//
// Top of the 9-bit buffer: pin-level write and read ports, APB control.
// Assumes all pins and the APB master are synchronous to pclk.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module fifo_top #(
    parameter int DATA_W = fifo_pkg::DATA_W,
    parameter int DEPTH  = fifo_pkg::DEPTH
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              primary_write_enable_n,
    input  wire logic              write_enable_two_or_load,
    input  wire logic              read_enable_n,
    input  wire logic              output_enable_n,
    output logic      [DATA_W-1:0] rdata,
    output logic                   rdata_oe,
    output logic                   full_flag_n,
    output logic                   empty_flag_n,
    output logic                   almost_empty_flag_n,
    output logic                   almost_full_flag_n,
    output logic                   irq
);
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int CNT_W  = ADDR_W + 1;

    // Detects a flag that has just gone to its active low level
    function automatic logic fell(input logic prev, input logic now);
        return prev & ~now;
    endfunction

    // Strap capture and pin mode
    logic                  strap_pending_q;
    fifo_pkg::pin_mode_t   mode_q;
    fifo_pkg::load_sel_t   load_sel_q;

    // Programmable offsets
    logic [ADDR_W-1:0]     ae_off_q;
    logic [ADDR_W-1:0]     af_off_q;

    // Flags from the occupancy tracker and their previous values
    logic [CNT_W-1:0]      count;
    logic                  full_n;
    logic                  empty_n;
    logic                  ae_n;
    logic                  af_n;
    logic                  full_n_prev_q;
    logic                  empty_n_prev_q;
    logic                  ae_n_prev_q;
    logic                  af_n_prev_q;

    // Interrupt state
    logic [fifo_pkg::EV_W-1:0] int_stat_q;
    logic [fifo_pkg::EV_W-1:0] int_mask_q;
    logic [fifo_pkg::EV_W-1:0] events;

    // APB state
    logic                  pready_q;
    logic                  pslverr_q;
    logic [31:0]           prdata_q;
    logic                  flush_q;
    logic                  oe_q;

    // Pin decode
    wire  wr_en_level   = ~primary_write_enable_n;
    wire  pin_level     = write_enable_two_or_load;
    wire  enable_mode   = mode_q == fifo_pkg::MODE_ENABLE;
    wire  data_strobe   = wr_en_level & pin_level & ~strap_pending_q;
    wire  load_strobe   = wr_en_level & ~pin_level & ~enable_mode & ~strap_pending_q;
    wire  wr_req        = data_strobe;
    wire  rd_req        = ~read_enable_n;
    wire  wr_ok         = wr_req & full_n & ~flush_q;
    wire  rd_ok         = rd_req & empty_n & ~flush_q;

    // APB decode
    wire  apb_access    = psel & penable & ~pready_q;
    wire  apb_done      = psel & penable & pready_q;
    wire  apb_wr        = apb_done & pwrite & ~pslverr_q;
    wire  hit_ctrl      = paddr == fifo_pkg::A_CTRL;
    wire  hit_status    = paddr == fifo_pkg::A_STATUS;
    wire  hit_ae        = paddr == fifo_pkg::A_AE_OFF;
    wire  hit_af        = paddr == fifo_pkg::A_AF_OFF;
    wire  hit_istat     = paddr == fifo_pkg::A_INT_STAT;
    wire  hit_imask     = paddr == fifo_pkg::A_INT_MASK;
    wire  hit_any       = hit_ctrl | hit_status | hit_ae | hit_af | hit_istat | hit_imask;
    wire  wr_ctrl       = apb_wr & hit_ctrl;
    wire  wr_ae         = apb_wr & hit_ae;
    wire  wr_af         = apb_wr & hit_af;
    wire  wr_istat      = apb_wr & hit_istat;
    wire  wr_imask      = apb_wr & hit_imask;

    // Read data selection; unmapped words read as zero
    logic [31:0] status_word;
    logic [31:0] rd_word;
    always_comb begin
        status_word = fifo_pkg::RD_ZERO;
        status_word[fifo_pkg::ST_FULL_N_BIT]  = full_n;
        status_word[fifo_pkg::ST_EMPTY_N_BIT] = empty_n;
        status_word[fifo_pkg::ST_AE_N_BIT]    = ae_n;
        status_word[fifo_pkg::ST_AF_N_BIT]    = af_n;
        status_word[fifo_pkg::ST_MODE_BIT]    = enable_mode;
        status_word[fifo_pkg::ST_COUNT_LSB +: CNT_W] = count;
    end

    assign rd_word = hit_status ? status_word :
                     hit_ae     ? {{(32-ADDR_W){1'b0}}, ae_off_q} :
                     hit_af     ? {{(32-ADDR_W){1'b0}}, af_off_q} :
                     hit_istat  ? {{(32-fifo_pkg::EV_W){1'b0}}, int_stat_q} :
                     hit_imask  ? {{(32-fifo_pkg::EV_W){1'b0}}, int_mask_q} :
                     fifo_pkg::RD_ZERO;

    // Events: a flag reaching its active level, or a refused request
    assign events[fifo_pkg::EV_FULL]  = fell(full_n_prev_q, full_n);
    assign events[fifo_pkg::EV_EMPTY] = fell(empty_n_prev_q, empty_n);
    assign events[fifo_pkg::EV_AE]    = fell(ae_n_prev_q, ae_n);
    assign events[fifo_pkg::EV_AF]    = fell(af_n_prev_q, af_n);
    assign events[fifo_pkg::EV_OVER]  = wr_req & ~full_n;
    assign events[fifo_pkg::EV_UNDER] = rd_req & ~empty_n;

    // Occupancy and flags
    fifo_occupancy #(
        .DEPTH     (DEPTH)
    ) u_occ (
        .pclk      (pclk),
        .presetn   (presetn),
        .flush     (flush_q),
        .wr        (wr_ok),
        .rd        (rd_ok),
        .ae_off    (ae_off_q),
        .af_off    (af_off_q),
        .count_q   (count),
        .full_n_q  (full_n),
        .empty_n_q (empty_n),
        .ae_n_q    (ae_n),
        .af_n_q    (af_n)
    );

    // Word storage; its read register drives the data pins directly
    fifo_storage #(
        .DATA_W  (DATA_W),
        .DEPTH   (DEPTH)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .flush   (flush_q),
        .wr      (wr_ok),
        .wdata   (wdata),
        .rd      (rd_ok),
        .rdata_q (rdata)
    );

    // Strap capture on the first edge after release; async reset may only load constants
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_pending_q <= 1'b1;
            mode_q          <= fifo_pkg::MODE_ENABLE;
        end else if (strap_pending_q) begin
            strap_pending_q <= 1'b0;
            mode_q          <= pin_level ? fifo_pkg::MODE_ENABLE : fifo_pkg::MODE_LOAD;
        end
    end

    // Offsets: a bus write wins over a pin load in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ae_off_q   <= ADDR_W'(fifo_pkg::AE_OFF_RST);
            af_off_q   <= ADDR_W'(fifo_pkg::AF_OFF_RST);
            load_sel_q <= fifo_pkg::LOAD_AE;
        end else if (wr_ae | wr_af) begin
            if (wr_ae) ae_off_q <= pwdata[ADDR_W-1:0];
            if (wr_af) af_off_q <= pwdata[ADDR_W-1:0];
        end else if (load_strobe) begin
            if (load_sel_q == fifo_pkg::LOAD_AE) begin
                ae_off_q   <= wdata[ADDR_W-1:0];
                load_sel_q <= fifo_pkg::LOAD_AF;
            end else begin
                af_off_q   <= wdata[ADDR_W-1:0];
                load_sel_q <= fifo_pkg::LOAD_AE;
            end
        end
    end

    // Output enable follows the pin one clock later; data register is low from reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= ~output_enable_n;
        end
    end

    // Previous flag levels for event detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_n_prev_q  <= 1'b1;
            empty_n_prev_q <= 1'b0;
            ae_n_prev_q    <= 1'b0;
            af_n_prev_q    <= 1'b1;
        end else begin
            full_n_prev_q  <= full_n;
            empty_n_prev_q <= empty_n;
            ae_n_prev_q    <= ae_n;
            af_n_prev_q    <= af_n;
        end
    end

    // Sticky status: a new event outranks a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= '0;
            int_mask_q <= '0;
            irq        <= 1'b0;
        end else begin
            int_stat_q <= (int_stat_q & ~(wr_istat ? pwdata[fifo_pkg::EV_W-1:0] : '0)) | events;
            if (wr_imask) int_mask_q <= pwdata[fifo_pkg::EV_W-1:0];
            irq        <= |(int_stat_q & int_mask_q);
        end
    end

    // Flush is a one-cycle pulse from the control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= wr_ctrl & pwdata[fifo_pkg::CTRL_FLUSH_BIT];
        end
    end

    // APB: one wait state, answer registered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= fifo_pkg::RD_ZERO;
        end else begin
            pready_q  <= apb_access;
            pslverr_q <= apb_access & ~hit_any;
            prdata_q  <= (apb_access & ~pwrite) ? rd_word : fifo_pkg::RD_ZERO;
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign rdata_oe            = oe_q;
    assign full_flag_n         = full_n;
    assign empty_flag_n        = empty_n;
    assign almost_empty_flag_n = ae_n;
    assign almost_full_flag_n  = af_n;
endmodule

// File: fifo_top_assertions.sv
// Port checks of the buffer: APB answer timing, flag levels, refusals, outputs.
// Assumes flush is never requested, so a local count can track occupancy.
`timescale 1ns/1ps
module fifo_checker #(
    parameter int DEPTH  = 64,
    parameter int DATA_W = 9
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              primary_write_enable_n,
    input wire logic              write_enable_two_or_load,
    input wire logic              read_enable_n,
    input wire logic              output_enable_n,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              rdata_oe,
    input wire logic              full_flag_n,
    input wire logic              empty_flag_n
);
    localparam int CW = $clog2(DEPTH) + 1;
    logic [CW-1:0] cnt_q;
    logic          arm_q;
    logic          wr_ok;
    logic          rd_ok;

    // Accepted operations; the first edge after reset only captures the pin mode
    assign wr_ok = arm_q && !primary_write_enable_n && write_enable_two_or_load && full_flag_n;
    assign rd_ok = !read_enable_n && empty_flag_n;

    // Occupancy as the pins imply it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            arm_q <= 1'b0;
        end else begin
            arm_q <= 1'b1;
            cnt_q <= cnt_q + CW'(wr_ok) - CW'(rd_ok);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence

    apb_answer_a: assert property (setup_s ##1 access_s |=> pready) else $error("pready late");
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    empty_level_a: assert property (empty_flag_n == (cnt_q != 0)) else $error("empty flag wrong");
    full_level_a: assert property (full_flag_n == (cnt_q != DEPTH)) else $error("full flag wrong");
    full_release_a: assert property (!full_flag_n && rd_ok |=> full_flag_n) else $error("full stuck");
    write_refuse_a: assert property (!full_flag_n && read_enable_n |=> !full_flag_n) else $error("full lost");
    read_refuse_a: assert property (!empty_flag_n && !read_enable_n |=> $stable(rdata)) else $error("rdata moved");
    oe_reset_a: assert property ($rose(presetn) ##1 !output_enable_n |=> rdata_oe && rdata == '0)
        else $error("output after reset");
    oe_off_a: assert property (output_enable_n |=> !rdata_oe) else $error("output not released");
endmodule

bind fifo_top fifo_checker #(.DEPTH(DEPTH), .DATA_W(DATA_W)) chk (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .primary_write_enable_n, .write_enable_two_or_load, .read_enable_n,
    .output_enable_n, .rdata, .rdata_oe, .full_flag_n, .empty_flag_n);

// File: fifo_reader.sv
// Reading agent on the far side of the read port.
// Assumes it shares pclk with the buffer; it pauses while slow is high.
`timescale 1ns/1ps
module fifo_reader #(
    parameter int DATA_W = 9
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              go,
    input  wire logic              slow,
    input  wire logic              empty_flag_n,
    input  wire logic [DATA_W-1:0] rdata,
    output logic                   read_enable_n,
    output logic                   got_v,
    output logic      [DATA_W-1:0] got_d
);
    // Keeps asking even while empty, since the buffer must refuse on its own
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_enable_n <= 1'b1;
            got_v         <= 1'b0;
        end else begin
            read_enable_n <= !(go && !slow);
            got_v         <= !read_enable_n && empty_flag_n;
        end
    end

    // Word is valid in the cycle after the accepting edge
    assign got_d = rdata;
endmodule

// File: tb_top.sv
// Self-checking bench for the 9-bit buffer: APB master, writer, reading agent.
// Assumes the package, design, reader model and checker are compiled first.
`timescale 1ns/1ps
module tb_top;
    localparam int DEPTH = fifo_pkg::DEPTH;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, go, slow, got_v;
    logic        primary_write_enable_n, write_enable_two_or_load, read_enable_n, err_v;
    logic        output_enable_n, rdata_oe, full_flag_n, empty_flag_n;
    logic        almost_empty_flag_n, almost_full_flag_n;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_v, seed;
    logic [8:0]  wdata, rdata, got_d;
    logic [8:0]  exp_q[$];
    int          errors, n_tests, cyc, ae_off, af_off, t;

    fifo_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .wdata, .primary_write_enable_n, .write_enable_two_or_load, .read_enable_n,
        .output_enable_n, .rdata, .rdata_oe, .full_flag_n, .empty_flag_n, .almost_empty_flag_n,
        .almost_full_flag_n, .irq);
    fifo_reader far (.pclk, .presetn, .go, .slow, .empty_flag_n, .rdata, .read_enable_n, .got_v, .got_d);

    function automatic logic [31:0] nxt(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    // Flags against an expected occupancy
    task automatic flags(input int lvl);
        chk("empty_flag_n", lvl != 0, empty_flag_n);
        chk("full_flag_n", lvl != DEPTH, full_flag_n);
        chk("almost_empty_flag_n", lvl >= ae_off, almost_empty_flag_n);
        chk("almost_full_flag_n", lvl < DEPTH - af_off, almost_full_flag_n);
    endtask

    // One APB transfer; an idle edge after it keeps psel from being driven twice at once
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v  = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Back-to-back random writes; flags seen at each edge show the previous write
    task automatic burst(input int n);
        for (int k = 0; k < n; k++) begin
            seed = nxt(seed);
            wdata <= seed[8:0];
            primary_write_enable_n <= 1'b0;
            @(posedge pclk);
            flags(exp_q.size());
            if (exp_q.size() < DEPTH) exp_q.push_back(wdata);
        end
        primary_write_enable_n <= 1'b1;
    endtask

    // Reader empties the buffer while stalling at random
    task automatic drain();
        go <= 1'b1;
        while (exp_q.size() > 0) begin
            seed = nxt(seed);
            slow <= seed[0];
            @(posedge pclk);
        end
        slow <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Hang guard: the run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            wrap_up();
        end
    end

    // Scoreboard: each word taken must be the oldest one noted
    always @(posedge pclk) begin
        if (got_v === 1'b1) begin
            if (exp_q.size() == 0) chk("spare word", 0, 1);
            else chk("rdata", exp_q.pop_front(), got_d);
            flags(exp_q.size());
        end
    end

    initial begin
        seed = 32'h0000_31ca;
        {presetn, psel, penable, pwrite, go, slow} = '0;
        {paddr, pwdata, wdata} = '0;
        primary_write_enable_n = 1'b1;
        write_enable_two_or_load = 1'b1;
        output_enable_n = 1'b0;
        ae_off = 7;
        af_off = 7;
        repeat (8) @(posedge pclk);
        flags(0);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("rdata_oe", 1, rdata_oe);
        chk("rdata", 0, rdata);
        output_enable_n <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("rdata_oe", 0, rdata_oe);
        apb(fifo_pkg::A_STATUS, 1'b0, '0);
        chk("mode", 1, rd_v[fifo_pkg::ST_MODE_BIT]);
        // Second enable low must block the write
        write_enable_two_or_load <= 1'b0;
        primary_write_enable_n <= 1'b0;
        @(posedge pclk);
        primary_write_enable_n <= 1'b1;
        write_enable_two_or_load <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("empty_flag_n", 0, empty_flag_n);
        burst(DEPTH + 2);
        @(posedge pclk);
        flags(exp_q.size());
        // Overflow event: masked, unmasked, then cleared
        chk("irq", 0, irq);
        apb(fifo_pkg::A_INT_MASK, 1'b1, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        chk("irq", 1, irq);
        apb(fifo_pkg::A_INT_STAT, 1'b0, '0);
        chk("overflow", 1, rd_v[fifo_pkg::EV_OVER]);
        apb(fifo_pkg::A_INT_STAT, 1'b1, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        chk("irq", 0, irq);
        apb(8'h3C, 1'b0, '0);
        chk("pslverr", 1, err_v);
        chk("prdata", 0, rd_v);
        drain();
        repeat (4) @(posedge pclk);
        burst(1);
        t = 0;
        while (got_v !== 1'b1 && t < 10) begin
            @(posedge pclk);
            t++;
        end
        chk("first_read_latency", 2, t);
        // Second reset mid-run with the pin low: load strobe mode
        go <= 1'b0;
        presetn <= 1'b0;
        write_enable_two_or_load <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        primary_write_enable_n <= 1'b0;
        wdata <= 9'h005;
        @(posedge pclk);
        wdata <= 9'h00a;
        @(posedge pclk);
        primary_write_enable_n <= 1'b1;
        write_enable_two_or_load <= 1'b1;
        @(posedge pclk);
        apb(fifo_pkg::A_AE_OFF, 1'b0, '0);
        chk("ae offset", 5, rd_v);
        apb(fifo_pkg::A_AF_OFF, 1'b0, '0);
        chk("af offset", 10, rd_v);
        apb(fifo_pkg::A_STATUS, 1'b0, '0);
        chk("mode", 0, rd_v[fifo_pkg::ST_MODE_BIT]);
        chk("empty_flag_n", 0, empty_flag_n);
        ae_off = 5;
        af_off = 10;
        burst(12);
        drain();
        repeat (4) @(posedge pclk);
        wrap_up();
    end
endmodule
